// File: hdl/addr_mode_params.svh
// Constants of the operand addressing unit
`ifndef ADDR_MODE_PARAMS_SVH
`define ADDR_MODE_PARAMS_SVH
`define AM_PFX_Y       8'h90
`define AM_PFX_YIND    8'h91
`define AM_PFX_IND     8'h92
`define AM_OPC_LEN     3'h1
`define AM_PAGE_TOP    16'h00FF
`define AM_SIDX_TOP    16'h01FE
`define AM_ADDR_INC    16'h0001
`endif

// File: hdl/am_pkg.sv
// Types of the operand addressing unit
package am_pkg;
    typedef enum logic [4:0] {
        AM_INH, AM_IMM, AM_DIR_S, AM_DIR_L, AM_IDX_0, AM_IDX_S, AM_IDX_L,
        AM_IND_S, AM_IND_L, AM_IIDX_S, AM_IIDX_L, AM_REL_D, AM_REL_I,
        AM_BIT_D, AM_BIT_I, AM_BITREL_D, AM_BITREL_I
    } addr_mode_type;

    typedef enum logic [1:0] {S_IDLE, S_FETCH, S_PTR, S_DONE} seq_state_type;

    typedef struct packed {
        addr_mode_type mode;
        logic          has_prefix;
        logic [7:0]    prefix;
        logic          rmw;
        logic [2:0]    bit_num;
        logic [15:0]   pc;
    } op_req_type;

    typedef struct packed {
        logic [15:0] ea;
        logic [7:0]  operand;
        logic [15:0] target;
        logic [2:0]  bit_num;
        logic [2:0]  length;
        logic        error;
    } op_res_type;
endpackage

// File: hdl/cpu_operand_address_modes.sv
// Operand byte counting and effective address forming for the core
// Overview of operation
// - Seventeen addressing modes in seven families are decoded.
// - Inherent instructions are one byte, two with prefix 90; no operand byte is fetched.
// - Immediate takes one byte after the opcode as the operand value.
// - Short direct takes one address byte, range 00 to FF.
// - Long direct takes a two-byte address reaching the full space.
// - Indexed address is unsigned sum of X or Y and the offset.
// - Indexed without offset fetches nothing; address is the index itself.
// - Short indexed takes one offset byte; range 00 to 1FE.
// - Long indexed takes a two-byte offset; sum reaches full space.
// - Indirect reads the operand address from a memory pointer at one-byte address.
// - Short indirect uses a byte pointer; addresses 00 to FF.
// - Indirect indexed adds X or Y to the fetched pointer, unsigned.
// - Short indirect indexed: byte pointer, one byte, range 00 to 1FE.
// - Branch target lies within -128..+127 of the following instruction.
// - Read-modify-write instructions accept short forms only.
// - Bit modes carry bit 0..7, direct or pointer address, optional offset.
// - Relative adds a signed byte offset, inline or from memory.
// - Prefix 90 selects Y and adds one byte.
// - Prefix 92 gives indirect forms; 91 gives Y indirect indexed.
`timescale 1ns/1ns
`include "addr_mode_params.svh"
module cpu_operand_address_modes (
    input  wire logic             sys_clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             start_i,
    input  wire am_pkg::op_req_type req_i,
    input  wire logic [7:0]       x_i,
    input  wire logic [7:0]       y_i,
    input  wire logic             fetch_valid_i,
    input  wire logic [7:0]       fetch_byte_i,
    input  wire logic             mem_valid_i,
    input  wire logic [7:0]       mem_data_i,
    output logic                  fetch_req_o,
    output logic                  mem_rd_o,
    output logic [15:0]           mem_addr_o,
    output logic                  busy_o,
    output logic                  done_o,
    output am_pkg::op_res_type    res_o
);
    logic [1:0]            rst_sync_r;
    logic                  rst_n;
    am_pkg::seq_state_type seq_r, seq_nxt;
    am_pkg::addr_mode_type mode_r, mode_nxt;
    am_pkg::op_res_type    res_r, res_nxt;
    logic        pfx_r, pfx_nxt, rmw_r, rmw_nxt, err_r, err_nxt;
    logic [2:0]  bnum_r, bnum_nxt;
    logic [15:0] pc_r, pc_nxt, addr_r, addr_nxt;
    logic [7:0]  idx_r, idx_nxt, b0_r, b0_nxt, b1_r, b1_nxt, p0_r, p0_nxt, p1_r, p1_nxt;
    logic [1:0]  bcnt_r, bcnt_nxt, pcnt_r, pcnt_nxt;
    logic        freq_r, freq_nxt, mrd_r, mrd_nxt, done_r, done_nxt, busy_r, busy_nxt;
    logic [2:0]  len;
    logic [15:0] npc, w_b, w_p;
    logic [7:0]  off, sbase;
    logic [8:0]  sum9;

    // Operand bytes that follow the opcode
    function automatic logic [1:0] stream_cnt(input am_pkg::addr_mode_type m);
        case (m)
            am_pkg::AM_INH, am_pkg::AM_IDX_0: stream_cnt = 2'h0;
            am_pkg::AM_DIR_L, am_pkg::AM_IDX_L, am_pkg::AM_BITREL_D, am_pkg::AM_BITREL_I:
                stream_cnt = 2'h2;
            default: stream_cnt = 2'h1;
        endcase
    endfunction

    // Pointer bytes read from data memory
    function automatic logic [1:0] ptr_cnt(input am_pkg::addr_mode_type m);
        case (m)
            am_pkg::AM_IND_L, am_pkg::AM_IIDX_L: ptr_cnt = 2'h2;
            am_pkg::AM_IND_S, am_pkg::AM_IIDX_S, am_pkg::AM_REL_I, am_pkg::AM_BIT_I, am_pkg::AM_BITREL_I:
                ptr_cnt = 2'h1;
            default: ptr_cnt = 2'h0;
        endcase
    endfunction

    function automatic logic is_long(input am_pkg::addr_mode_type m);
        is_long = (m == am_pkg::AM_DIR_L) || (m == am_pkg::AM_IDX_L) ||
                  (m == am_pkg::AM_IND_L) || (m == am_pkg::AM_IIDX_L);
    endfunction

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    assign len   = `AM_OPC_LEN + {2'h0, pfx_r} + {1'b0, stream_cnt(mode_r)};
    assign npc   = pc_r + {13'h0, len};
    assign w_b   = {b0_r, b1_r};
    assign w_p   = {p0_r, p1_r};
    assign sbase = (mode_r == am_pkg::AM_IIDX_S) ? p0_r : b0_r;
    assign sum9  = {1'b0, sbase} + {1'b0, idx_r};
    assign off   = (mode_r == am_pkg::AM_REL_D) ? b0_r :
                   (mode_r == am_pkg::AM_REL_I) ? p0_r : b1_r;

    always_comb begin
        am_pkg::addr_mode_type am;
        logic y;
        logic e;
        am = req_i.mode;
        y = 1'b0;
        e = 1'b0;
        seq_nxt = seq_r;   mode_nxt = mode_r; pfx_nxt = pfx_r;  rmw_nxt = rmw_r;
        err_nxt = err_r;   bnum_nxt = bnum_r; pc_nxt = pc_r;    idx_nxt = idx_r;
        b0_nxt = b0_r;     b1_nxt = b1_r;     p0_nxt = p0_r;    p1_nxt = p1_r;
        bcnt_nxt = bcnt_r; pcnt_nxt = pcnt_r; freq_nxt = freq_r; mrd_nxt = mrd_r;
        addr_nxt = addr_r; res_nxt = res_r;   done_nxt = 1'b0;
        case (seq_r)
            am_pkg::S_IDLE: if (start_i) begin
                if (req_i.has_prefix) begin
                    case (req_i.prefix)
                        `AM_PFX_Y: begin
                            y = 1'b1;
                            if (!(am inside {am_pkg::AM_INH, am_pkg::AM_IMM, am_pkg::AM_DIR_S, am_pkg::AM_DIR_L,
                                             am_pkg::AM_IDX_0, am_pkg::AM_IDX_S, am_pkg::AM_IDX_L}))
                                e = 1'b1;
                        end
                        `AM_PFX_IND, `AM_PFX_YIND: begin
                            y = (req_i.prefix == `AM_PFX_YIND);
                            case (req_i.mode)
                                am_pkg::AM_IDX_S: am = am_pkg::AM_IIDX_S;
                                am_pkg::AM_IDX_L: am = am_pkg::AM_IIDX_L;
                                am_pkg::AM_DIR_S: am = am_pkg::AM_IND_S;
                                am_pkg::AM_DIR_L: am = am_pkg::AM_IND_L;
                                am_pkg::AM_REL_D: am = am_pkg::AM_REL_I;
                                am_pkg::AM_BIT_D: am = am_pkg::AM_BIT_I;
                                am_pkg::AM_BITREL_D: am = am_pkg::AM_BITREL_I;
                                default: e = 1'b1;
                            endcase
                            if (y && !(am inside {am_pkg::AM_IIDX_S, am_pkg::AM_IIDX_L}))
                                e = 1'b1;
                        end
                        default: e = 1'b1;
                    endcase
                end else if (am inside {am_pkg::AM_IND_S, am_pkg::AM_IND_L, am_pkg::AM_IIDX_S, am_pkg::AM_IIDX_L,
                                        am_pkg::AM_REL_I, am_pkg::AM_BIT_I, am_pkg::AM_BITREL_I}) begin
                    e = 1'b1;
                end
                if (req_i.rmw && is_long(am))
                    e = 1'b1;
                mode_nxt = am;
                pfx_nxt  = req_i.has_prefix;
                rmw_nxt  = req_i.rmw;
                err_nxt  = e;
                bnum_nxt = req_i.bit_num;
                pc_nxt   = req_i.pc;
                idx_nxt  = y ? y_i : x_i;
                bcnt_nxt = 2'h0;
                pcnt_nxt = 2'h0;
                if (e || stream_cnt(am) == 2'h0) begin
                    seq_nxt = am_pkg::S_DONE;
                end else begin
                    seq_nxt  = am_pkg::S_FETCH;
                    freq_nxt = 1'b1;
                end
            end
            am_pkg::S_FETCH: if (fetch_valid_i) begin
                if (bcnt_r == 2'h0)
                    b0_nxt = fetch_byte_i;
                else
                    b1_nxt = fetch_byte_i;
                bcnt_nxt = bcnt_r + 2'h1;
                if (bcnt_r + 2'h1 == stream_cnt(mode_r)) begin
                    freq_nxt = 1'b0;
                    if (ptr_cnt(mode_r) != 2'h0) begin
                        seq_nxt  = am_pkg::S_PTR;
                        mrd_nxt  = 1'b1;
                        addr_nxt = {8'h00, (bcnt_r == 2'h0) ? fetch_byte_i : b0_r};
                    end else begin
                        seq_nxt = am_pkg::S_DONE;
                    end
                end
            end
            am_pkg::S_PTR: if (mem_valid_i) begin
                if (pcnt_r == 2'h0)
                    p0_nxt = mem_data_i;
                else
                    p1_nxt = mem_data_i;
                pcnt_nxt = pcnt_r + 2'h1;
                if (pcnt_r + 2'h1 == ptr_cnt(mode_r)) begin
                    mrd_nxt = 1'b0;
                    seq_nxt = am_pkg::S_DONE;
                end else begin
                    addr_nxt = addr_r + `AM_ADDR_INC;
                end
            end
            am_pkg::S_DONE: begin
                res_nxt.ea      = 16'h0000;
                res_nxt.operand = 8'h00;
                res_nxt.target  = npc;
                res_nxt.bit_num = bnum_r;
                res_nxt.length  = len;
                res_nxt.error   = err_r;
                case (mode_r)
                    am_pkg::AM_IMM:    res_nxt.operand = b0_r;
                    am_pkg::AM_DIR_S, am_pkg::AM_BIT_D, am_pkg::AM_BITREL_D:
                        res_nxt.ea = {8'h00, b0_r};
                    am_pkg::AM_DIR_L:  res_nxt.ea = w_b;
                    am_pkg::AM_IDX_0:  res_nxt.ea = {8'h00, idx_r};
                    am_pkg::AM_IDX_S, am_pkg::AM_IIDX_S:
                        res_nxt.ea = {7'h00, sum9};
                    am_pkg::AM_IDX_L:  res_nxt.ea = w_b + {8'h00, idx_r};
                    am_pkg::AM_IND_S, am_pkg::AM_BIT_I, am_pkg::AM_BITREL_I:
                        res_nxt.ea = {8'h00, p0_r};
                    am_pkg::AM_IND_L:  res_nxt.ea = w_p;
                    am_pkg::AM_IIDX_L: res_nxt.ea = w_p + {8'h00, idx_r};
                    default:           res_nxt.ea = 16'h0000;
                endcase
                if (mode_r inside {am_pkg::AM_REL_D, am_pkg::AM_REL_I, am_pkg::AM_BITREL_D, am_pkg::AM_BITREL_I})
                    res_nxt.target = npc + {{8{off[7]}}, off};
                done_nxt = 1'b1;
                seq_nxt  = am_pkg::S_IDLE;
            end
            default: seq_nxt = am_pkg::S_IDLE;
        endcase
        busy_nxt = (seq_nxt != am_pkg::S_IDLE);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= am_pkg::S_IDLE; mode_r <= am_pkg::AM_INH; res_r <= '0;
            pfx_r <= 1'b0;  rmw_r <= 1'b0;  err_r <= 1'b0;  bnum_r <= 3'h0;
            pc_r <= 16'h0000; addr_r <= 16'h0000; idx_r <= 8'h00;
            b0_r <= 8'h00;  b1_r <= 8'h00;  p0_r <= 8'h00;  p1_r <= 8'h00;
            bcnt_r <= 2'h0; pcnt_r <= 2'h0; freq_r <= 1'b0; mrd_r <= 1'b0;
            done_r <= 1'b0; busy_r <= 1'b0;
        end else begin
            seq_r <= seq_nxt; mode_r <= mode_nxt; res_r <= res_nxt;
            pfx_r <= pfx_nxt; rmw_r <= rmw_nxt; err_r <= err_nxt; bnum_r <= bnum_nxt;
            pc_r <= pc_nxt;   addr_r <= addr_nxt; idx_r <= idx_nxt;
            b0_r <= b0_nxt;   b1_r <= b1_nxt; p0_r <= p0_nxt; p1_r <= p1_nxt;
            bcnt_r <= bcnt_nxt; pcnt_r <= pcnt_nxt; freq_r <= freq_nxt; mrd_r <= mrd_nxt;
            done_r <= done_nxt; busy_r <= busy_nxt;
        end
    end

    assign fetch_req_o = freq_r;
    assign mem_rd_o    = mrd_r;
    assign mem_addr_o  = addr_r;
    assign busy_o      = busy_r;
    assign done_o      = done_r;
    assign res_o       = res_r;

    // Operand bytes taken since the last start
    logic [2:0] take_cnt;
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n)
            take_cnt <= 3'h0;
        else if (seq_r == am_pkg::S_IDLE && start_i)
            take_cnt <= 3'h0;
        else if (freq_r && fetch_valid_i)
            take_cnt <= take_cnt + 3'h1;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    inherent_one_byte_a: assert property (
        (seq_r == am_pkg::S_IDLE && start_i && req_i.mode == am_pkg::AM_INH && !req_i.has_prefix && !req_i.rmw)
        |-> !fetch_req_o [*3] ##0 done_o && res_o.length == 3'h1)
        else $error("inherent instruction length wrong");
    imm_operand_a: assert property (
        done_o && !res_o.error && mode_r == am_pkg::AM_IMM |-> res_o.operand == b0_r && take_cnt == 3'h1)
        else $error("immediate operand wrong");
    short_direct_a: assert property (
        done_o && mode_r == am_pkg::AM_DIR_S && !err_r |-> res_o.ea <= `AM_PAGE_TOP && res_o.ea[7:0] == b0_r)
        else $error("short direct address wrong");
    long_direct_a: assert property (
        done_o && mode_r == am_pkg::AM_DIR_L && !err_r |-> res_o.ea == w_b && take_cnt == 3'h2)
        else $error("long direct address wrong");
    no_offset_idx_a: assert property (
        done_o && mode_r == am_pkg::AM_IDX_0 && !err_r |-> res_o.ea == {8'h00, idx_r} && take_cnt == 3'h0)
        else $error("no offset indexed address wrong");
    short_idx_sum_a: assert property (
        done_o && mode_r == am_pkg::AM_IDX_S && !err_r
        |-> res_o.ea <= `AM_SIDX_TOP && res_o.ea == {8'h00, b0_r} + {8'h00, idx_r})
        else $error("short indexed sum wrong");
    long_idx_sum_a: assert property (
        done_o && mode_r == am_pkg::AM_IDX_L && !err_r |-> res_o.ea == 16'(w_b + {8'h00, idx_r}))
        else $error("long indexed sum wrong");
    ptr_address_a: assert property (
        $rose(mem_rd_o) |-> mem_addr_o == {8'h00, b0_r} ##1 (mem_rd_o || done_o || seq_r == am_pkg::S_DONE))
        else $error("pointer address wrong");
    short_iidx_a: assert property (
        done_o && mode_r == am_pkg::AM_IIDX_S && !err_r
        |-> res_o.ea == {8'h00, p0_r} + {8'h00, idx_r} && take_cnt == 3'h1)
        else $error("short indirect indexed address wrong");
    rel_target_a: assert property (
        done_o && mode_r == am_pkg::AM_REL_D && !err_r |-> res_o.target == 16'(npc + {{8{b0_r[7]}}, b0_r}))
        else $error("relative target wrong");
    rmw_short_a: assert property (
        done_o && rmw_r && is_long(mode_r) |-> res_o.error)
        else $error("long form accepted for read-modify-write");

    cover_long_ind: cover property (done_o && mode_r == am_pkg::AM_IIDX_L && !res_o.error);
    cover_bitrel_i: cover property (done_o && mode_r == am_pkg::AM_BITREL_I && !res_o.error);
    cover_y_prefix: cover property (done_o && pfx_r && mode_r == am_pkg::AM_IDX_S && !res_o.error);
    cover_error:    cover property (done_o && res_o.error);
endmodule

// File: dv/op_mem_model.sv
// Program byte stream and data memory answering the operand addressing unit
`timescale 1ns/1ns
module op_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        slow_i,
    input  wire logic        fetch_req_i,
    input  wire logic        mem_rd_i,
    input  wire logic [15:0] mem_addr_i,
    output logic             fetch_valid_o,
    output logic [7:0]       fetch_byte_o,
    output logic             mem_valid_o,
    output logic [7:0]       mem_data_o
);
    logic [7:0] prog  [0:3];
    logic [7:0] store [0:65535];
    logic [1:0] idx_r;
    logic       phase_r;

    // Slow mode answers every other cycle only
    assign fetch_valid_o = fetch_req_i & (phase_r | ~slow_i);
    assign mem_valid_o   = mem_rd_i & (phase_r | ~slow_i);
    // Lines not carrying a valid byte show the inverse so stale data never matches
    assign fetch_byte_o  = fetch_valid_o ? prog[idx_r] : ~prog[idx_r];
    assign mem_data_o    = mem_valid_o ? store[mem_addr_i] : ~store[mem_addr_i];

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            idx_r   <= 2'h0;
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
            if (!fetch_req_i)
                idx_r <= 2'h0;
            else if (fetch_valid_o)
                idx_r <= idx_r + 2'h1;
        end
    end
endmodule

// File: dv/cpu_operand_address_modes_bench.sv
// Self-checking bench for the operand addressing unit
`timescale 1ns/1ns
module cpu_operand_address_modes_bench;
    logic               sys_clk_i;
    logic               arst_n_i;
    logic               start_i;
    am_pkg::op_req_type req_i;
    logic [7:0]         x_i;
    logic [7:0]         y_i;
    logic               slow;
    logic               fetch_valid_i;
    logic [7:0]         fetch_byte_i;
    logic               mem_valid_i;
    logic [7:0]         mem_data_i;
    logic               fetch_req_o;
    logic               mem_rd_o;
    logic [15:0]        mem_addr_o;
    logic               busy_o;
    logic               done_o;
    am_pkg::op_res_type res_o;
    am_pkg::op_res_type res;
    int                 fail_count;
    int                 cmp_count;
    int                 n_cyc;
    int                 n_fetch;
    int                 n_ptr;
    logic [15:0]        ptr_addr;

    cpu_operand_address_modes DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .req_i(req_i),
        .x_i(x_i), .y_i(y_i), .fetch_valid_i(fetch_valid_i), .fetch_byte_i(fetch_byte_i), .mem_valid_i(mem_valid_i),
        .mem_data_i(mem_data_i), .fetch_req_o(fetch_req_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
        .busy_o(busy_o), .done_o(done_o), .res_o(res_o));
    op_mem_model mem_model (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .slow_i(slow), .fetch_req_i(fetch_req_o),
        .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .fetch_valid_o(fetch_valid_i), .fetch_byte_o(fetch_byte_i),
        .mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));

    always #10 sys_clk_i = ~sys_clk_i;

    // Counts bytes actually taken on both ports
    always @(posedge sys_clk_i) begin
        if (fetch_req_o === 1'b1 && fetch_valid_i === 1'b1)
            n_fetch++;
        if (mem_rd_o === 1'b1 && mem_valid_i === 1'b1) begin
            if (n_ptr == 0)
                ptr_addr = mem_addr_o;
            n_ptr++;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic op(input am_pkg::addr_mode_type md, input logic [7:0] pfx, input logic rmw, input logic [2:0] bn,
                      input logic [15:0] pc, input logic [7:0] xv, input logic [7:0] yv, input logic [7:0] b0,
                      input logic [7:0] b1, input logic slw);
        @(posedge sys_clk_i);
        mem_model.prog[0] = b0;
        mem_model.prog[1] = b1;
        n_fetch = 0;
        n_ptr = 0;
        ptr_addr = 16'h0000;
        n_cyc = 0;
        slow <= slw;
        start_i <= 1'b1;
        req_i <= '{mode: md, has_prefix: (pfx != 8'h00), prefix: pfx, rmw: rmw, bit_num: bn, pc: pc};
        x_i <= xv;
        y_i <= yv;
        @(posedge sys_clk_i);
        start_i <= 1'b0;
        while (done_o !== 1'b1) begin
            @(posedge sys_clk_i);
            #1;
            n_cyc++;
            if (n_cyc > 60) begin
                fail_count++;
                test_done();
            end
            if (done_o !== 1'b1)
                check(busy_o, 1'b1);
        end
        res = res_o;
        check(busy_o, 1'b0);
    endtask

    task automatic chk(input logic [15:0] ea, input logic [2:0] len, input int nf, input int np, input logic [15:0] pa);
        check(res.ea, ea);
        check(res.length, len);
        check(res.error, 1'b0);
        check(n_fetch, nf);
        check(n_ptr, np);
        if (np > 0)
            check(ptr_addr, pa);
    endtask

    task automatic sc_inherent_immediate;
        op(am_pkg::AM_INH, 8'h00, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h11, 8'h22, 1'b0);
        chk(16'h0000, 3'h1, 0, 0, 16'h0000);
        check(n_cyc, 1);
        op(am_pkg::AM_INH, 8'h90, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h11, 8'h22, 1'b0);
        chk(16'h0000, 3'h2, 0, 0, 16'h0000);
        op(am_pkg::AM_IMM, 8'h00, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h55, 8'hAA, 1'b1);
        chk(16'h0000, 3'h2, 1, 0, 16'h0000);
        check(res.operand, 8'h55);
    endtask

    task automatic sc_direct_indexed;
        op(am_pkg::AM_DIR_S, 8'h00, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h10, 8'h99, 1'b0);
        chk(16'h0010, 3'h2, 1, 0, 16'h0000);
        check(n_cyc, 2);
        op(am_pkg::AM_DIR_L, 8'h00, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h12, 8'h34, 1'b1);
        chk(16'h1234, 3'h3, 2, 0, 16'h0000);
        op(am_pkg::AM_IDX_0, 8'h00, 1'b0, 3'h0, 16'h0100, 8'h80, 8'h07, 8'h66, 8'h77, 1'b0);
        chk(16'h0080, 3'h1, 0, 0, 16'h0000);
        op(am_pkg::AM_IDX_0, 8'h90, 1'b0, 3'h0, 16'h0100, 8'h11, 8'hC3, 8'h66, 8'h77, 1'b0);
        chk(16'h00C3, 3'h2, 0, 0, 16'h0000);
        op(am_pkg::AM_IDX_S, 8'h00, 1'b0, 3'h0, 16'h0100, 8'hFF, 8'h01, 8'hFF, 8'h77, 1'b0);
        chk(16'h01FE, 3'h2, 1, 0, 16'h0000);
        op(am_pkg::AM_IDX_L, 8'h90, 1'b0, 3'h0, 16'h0100, 8'h01, 8'h10, 8'hFF, 8'hF8, 1'b1);
        chk(16'h0008, 3'h4, 2, 0, 16'h0000);
    endtask

    task automatic sc_indirect;
        mem_model.store[16'h0020] = 8'h77;
        mem_model.store[16'h0030] = 8'hAB;
        mem_model.store[16'h0031] = 8'hCD;
        mem_model.store[16'h0040] = 8'hFF;
        mem_model.store[16'h0050] = 8'hFF;
        mem_model.store[16'h0051] = 8'hFF;
        op(am_pkg::AM_DIR_S, 8'h92, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h20, 8'h00, 1'b1);
        chk(16'h0077, 3'h3, 1, 1, 16'h0020);
        op(am_pkg::AM_DIR_L, 8'h92, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h30, 8'h00, 1'b0);
        chk(16'hABCD, 3'h3, 1, 2, 16'h0030);
        op(am_pkg::AM_IDX_S, 8'h92, 1'b0, 3'h0, 16'h0100, 8'hF0, 8'h00, 8'h40, 8'h00, 1'b0);
        chk(16'h01EF, 3'h3, 1, 1, 16'h0040);
        op(am_pkg::AM_IDX_L, 8'h91, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h02, 8'h50, 8'h00, 1'b1);
        chk(16'h0001, 3'h3, 1, 2, 16'h0050);
    endtask

    task automatic sc_relative_bit;
        mem_model.store[16'h0060] = 8'h05;
        mem_model.store[16'h0070] = 8'h33;
        mem_model.store[16'h0080] = 8'h44;
        op(am_pkg::AM_REL_D, 8'h00, 1'b0, 3'h0, 16'h1000, 8'h00, 8'h00, 8'h80, 8'h00, 1'b0);
        check(res.target, 16'h0F82);
        op(am_pkg::AM_REL_D, 8'h00, 1'b0, 3'h0, 16'h1000, 8'h00, 8'h00, 8'h7F, 8'h00, 1'b0);
        check(res.target, 16'h1081);
        op(am_pkg::AM_REL_D, 8'h92, 1'b0, 3'h0, 16'h2000, 8'h00, 8'h00, 8'h60, 8'h00, 1'b1);
        chk(16'h0000, 3'h3, 1, 1, 16'h0060);
        check(res.target, 16'h2008);
        op(am_pkg::AM_BIT_D, 8'h00, 1'b0, 3'h7, 16'h0100, 8'h00, 8'h00, 8'h10, 8'h00, 1'b0);
        chk(16'h0010, 3'h2, 1, 0, 16'h0000);
        check(res.bit_num, 3'h7);
        op(am_pkg::AM_BIT_D, 8'h92, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h80, 8'h00, 1'b0);
        chk(16'h0044, 3'h3, 1, 1, 16'h0080);
        op(am_pkg::AM_BITREL_D, 8'h00, 1'b0, 3'h5, 16'h0400, 8'h00, 8'h00, 8'h12, 8'h10, 1'b0);
        chk(16'h0012, 3'h3, 2, 0, 16'h0000);
        check(res.target, 16'h0413);
        op(am_pkg::AM_BITREL_D, 8'h92, 1'b0, 3'h3, 16'h3000, 8'h00, 8'h00, 8'h70, 8'hFE, 1'b1);
        chk(16'h0033, 3'h4, 2, 1, 16'h0070);
        check(res.target, 16'h3002);
        check(res.bit_num, 3'h3);
    endtask

    task automatic sc_refusals;
        op(am_pkg::AM_DIR_L, 8'h00, 1'b1, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h12, 8'h34, 1'b0);
        check(res.error, 1'b1);
        check(n_fetch, 0);
        check(n_cyc, 1);
        op(am_pkg::AM_IDX_L, 8'h00, 1'b1, 3'h0, 16'h0100, 8'h01, 8'h00, 8'h12, 8'h34, 1'b0);
        check(res.error, 1'b1);
        op(am_pkg::AM_DIR_S, 8'h00, 1'b1, 3'h0, 16'h0100, 8'h00, 8'h00, 8'hF0, 8'h00, 1'b0);
        chk(16'h00F0, 3'h2, 1, 0, 16'h0000);
        op(am_pkg::AM_IND_S, 8'h00, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h20, 8'h00, 1'b0);
        check(res.error, 1'b1);
        // Prefix on a mode it cannot modify is refused without fetching
        op(am_pkg::AM_REL_D, 8'h90, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h20, 8'h00, 1'b0);
        check(res.error, 1'b1);
        check(n_fetch, 0);
        op(am_pkg::AM_DIR_S, 8'h91, 1'b0, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h20, 8'h00, 1'b0);
        check(res.error, 1'b1);
        op(am_pkg::AM_DIR_L, 8'h92, 1'b1, 3'h0, 16'h0100, 8'h00, 8'h00, 8'h30, 8'h00, 1'b0);
        check(res.error, 1'b1);
        check(n_ptr, 0);
    endtask

    initial begin
        sys_clk_i = 1'b0;
        arst_n_i = 1'b0;
        start_i = 1'b0;
        req_i = '0;
        x_i = 8'h00;
        y_i = 8'h00;
        slow = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        sc_inherent_immediate();
        sc_direct_indexed();
        sc_indirect();
        sc_relative_bit();
        sc_refusals();
        test_done();
    end
endmodule
